// ### cfs_host_model.sv
// Host side model issuing register accesses and control pulses.
`timescale 1ns/100ps
`default_nettype none

module cfs_host_model
    import cfs_pkg::*;
(
    input wire logic clk,
    input wire logic readValid,
    input wire cfs_byte_t readData,
    output logic chipSelectN,
    output var cfs_acc_t regAccess,
    output logic [7:0] regAddr,
    output var cfs_chan_t timerConfigWrite,
    output logic softReset,
    output logic timedOut
);
    // ==========================================================
    // Idle state: deselected, nothing requested.
    initial begin
        chipSelectN = 1'b1;
        regAccess = CFS_ACC_NONE;
        regAddr = 8'h00;
        timerConfigWrite = 4'h0;
        softReset = 1'b0;
        timedOut = 1'b0;
    end

    // The address is inverted once released so a stale value never helps.
    task automatic access(input cfs_acc_t k, input logic [7:0] a,
                          output cfs_byte_t d);
        int i = 0;
        @(posedge clk);
        regAccess <= k;
        regAddr <= a;
        @(posedge clk);
        regAccess <= CFS_ACC_NONE;
        regAddr <= ~a;
        // The answer pulse stands only in the cycle after the request edge.
        #1;
        while (readValid !== 1'b1 && i < 4) begin
            @(posedge clk);
            #1;
            i++;
        end
        timedOut = (readValid !== 1'b1);
        d = readData;
    endtask

    // Timer writes re-enable latched channels; then one cycle to settle.
    task automatic ctrl(input cfs_chan_t tw, input logic sr);
        @(posedge clk);
        timerConfigWrite <= tw;
        softReset <= sr;
        @(posedge clk);
        timerConfigWrite <= 4'h0;
        softReset <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // Frame control: low while the host talks on the link.
    task automatic setCs(input logic v);
        @(posedge clk);
        chipSelectN <= v;
    endtask
endmodule // cfs_host_model
`default_nettype wire

// ### cfs_pkg.sv
// Types shared by the channel fault status logic.
package cfs_pkg;

    // One bit per output channel.
    typedef logic [3:0] cfs_chan_t;

    // Register data word as seen by the serial link.
    typedef logic [7:0] cfs_byte_t;

    // Kind of register access requested by the serial front end.
    typedef enum logic [1:0] {
        CFS_ACC_NONE,
        CFS_ACC_READ,
        CFS_ACC_READCLR
    } cfs_acc_t;

endpackage

// ### cfs_regs_map.svh
// Register offsets, field positions and reset values of the fault flags.
`ifndef CFS_REGS_MAP_SVH
`define CFS_REGS_MAP_SVH

// ==========================================================
// Register map
`define CFS_ADDR_W 8
`define CFS_DATA_W 8
`define CFS_OFF_LATCHOFF 8'h32
`define CFS_OFF_DSFAULT 8'h33

// ==========================================================
// Field layout
`define CFS_NUM_CH 4
`define CFS_FLAG_LSB 0
`define CFS_FLAG_MSB 3
`define CFS_RSVD_LSB 4
`define CFS_RSVD_MSB 7

// ==========================================================
// Reset values
`define CFS_RST_LATCHOFF 4'h0
`define CFS_RST_DSFAULT 4'h0
`define CFS_RST_RDATA 8'h00

`endif

// ### cfs_status_regs.sv
// Latch-off and drain-source fault flag registers of a four channel driver.
//
// What this block does
// RULE1 - Latch-off flags: bits 3..0 read-only, bits 7..4 zero, reset 0.
// RULE2 - Power-limit or overtemperature latch-off sets the channel's flag.
// RULE3 - A latchoff_timer_config write clears its channel's latch-off flag.
// RULE4 - A software reset clears every latch-off flag.
// RULE5 - Turn-off sets the drain-source flag if the drop is over threshold.
// RULE6 - A drain-source flag holds until that channel's next turn-off or a read-and-clear.
// RULE7 - Read-and-clear returns the drain-source flags and then clears them.
// RULE8 - A drain-source flag of one means high drop seen, zero means none.
// RULE9 - Hardware events do not update status while chip_select_n is low.
// RULE10 - Any set latch-off flag shows in the global status byte.
`include "cfs_regs_map.svh"
`timescale 1ns/100ps
`default_nettype none

module cfs_status_regs
    import cfs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    // Chip select pin of the serial link, low during a frame.
    input wire logic chipSelectN,
    // Register access from the serial front end, same clock.
    input wire cfs_acc_t regAccess,
    input wire logic [`CFS_ADDR_W-1:0] regAddr,
    // One pulse per channel when its timer configuration is written.
    input wire cfs_chan_t timerConfigWrite,
    input wire logic softReset,
    // Protection and control events, one-cycle pulses, same clock.
    input wire cfs_chan_t latchOffEvent,
    input wire cfs_chan_t commandOffEvent,
    // Overload comparator outputs, asynchronous to clk.
    input wire cfs_chan_t overloadCmp,
    output var cfs_byte_t readData,
    output logic readValid,
    output var cfs_chan_t channelLatchedOff,
    output logic globalLatchOff
);

    // ==========================================================
    // Pin synchronisers

    logic csSyncA_q;
    logic csSyncB_q;
    cfs_chan_t cmpSyncA_q;
    cfs_chan_t cmpSyncB_q;
    logic csSyncA_d;
    logic csSyncB_d;
    cfs_chan_t cmpSyncA_d;
    cfs_chan_t cmpSyncB_d;

    // The first stage feeds only the second, so metastability stays put.
    always_comb begin
        csSyncA_d = chipSelectN;
        csSyncB_d = csSyncA_q;
        cmpSyncA_d = overloadCmp;
        cmpSyncB_d = cmpSyncA_q;
    end

    // Chip select resets high so the block starts out of a frame.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            csSyncA_q <= 1'b1;
            csSyncB_q <= 1'b1;
            cmpSyncA_q <= 4'h0;
            cmpSyncB_q <= 4'h0;
        end else begin
            csSyncA_q <= csSyncA_d;
            csSyncB_q <= csSyncB_d;
            cmpSyncA_q <= cmpSyncA_d;
            cmpSyncB_q <= cmpSyncB_d;
        end
    end

    // ==========================================================
    // Event qualification

    logic frozen;
    logic hitLatch;
    logic hitFault;
    logic isRead;
    logic faultReadClr;
    cfs_chan_t turnOff;
    cfs_chan_t evalNow;
    cfs_chan_t latchSetNow;
    // Parked latch-off events, registered in the latch-off section below.
    cfs_chan_t pendLatch_q;

    // Hardware events are held off for the whole frame; a turn-off that
    // lands inside a frame is not seen by the drain-source flags.
    always_comb begin
        frozen = ~csSyncB_q; // [RULE9]
        hitLatch = (regAddr == `CFS_OFF_LATCHOFF);
        hitFault = (regAddr == `CFS_OFF_DSFAULT);
        isRead = (regAccess == CFS_ACC_READ) ||
                 (regAccess == CFS_ACC_READCLR);
        faultReadClr = (regAccess == CFS_ACC_READCLR) && hitFault;
        turnOff = latchOffEvent | commandOffEvent;
        evalNow = frozen ? 4'h0 : turnOff; // [RULE9]
        latchSetNow = frozen ? 4'h0 : (latchOffEvent | pendLatch_q);
    end

    // ==========================================================
    // Latch-off flags

    cfs_chan_t pendLatch_d;
    cfs_chan_t latchFlags_q;
    cfs_chan_t latchFlags_d;
    logic anyLatch_q;
    logic anyLatch_d;

    // A latch-off that happens during a frame is parked and posted when
    // chip select rises, since the channel stays off and must be seen.
    // A latch event wins over a timer write in the same cycle.
    always_comb begin
        pendLatch_d = frozen ? (pendLatch_q | latchOffEvent) : 4'h0;
        latchFlags_d = latchFlags_q & ~timerConfigWrite; // [RULE3]
        latchFlags_d = latchFlags_d | latchSetNow; // [RULE2]
        if (softReset) begin
            pendLatch_d = 4'h0;
            latchFlags_d = `CFS_RST_LATCHOFF; // [RULE4]
        end
        anyLatch_d = |latchFlags_d; // [RULE10]
    end

    // Flags and the global summary share one next value, so they agree.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pendLatch_q <= 4'h0;
            latchFlags_q <= `CFS_RST_LATCHOFF; // [RULE1]
            anyLatch_q <= 1'b0;
        end else begin
            pendLatch_q <= pendLatch_d;
            latchFlags_q <= latchFlags_d;
            anyLatch_q <= anyLatch_d;
        end
    end

    // ==========================================================
    // Drain-source fault flags

    cfs_chan_t dsFlags_q;
    cfs_chan_t dsFlags_d;

    // Each turn-off outside a frame re-evaluates the channel: one means high drop, zero
    // means none. A detection in the read-clear cycle survives the clear.
    always_comb begin
        dsFlags_d = faultReadClr ? 4'h0 : dsFlags_q; // [RULE7]
        for (int i = 0; i < `CFS_NUM_CH; i++) begin
            if (evalNow[i]) begin
                dsFlags_d[i] = cmpSyncB_q[i]; // [RULE5] [RULE8]
            end
        end
    end

    // Between turn-offs the flag only moves on a read-and-clear.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dsFlags_q <= `CFS_RST_DSFAULT;
        end else begin
            dsFlags_q <= dsFlags_d; // [RULE6]
        end
    end

    // ==========================================================
    // Read port

    cfs_byte_t readData_q;
    cfs_byte_t readData_d;
    logic readValid_q;
    logic readValid_d;

    // Reads return the value before any clear; upper bits and unmapped
    // addresses read as zero.
    always_comb begin
        readData_d = `CFS_RST_RDATA;
        readValid_d = isRead;
        if (isRead && hitLatch) begin
            readData_d[`CFS_FLAG_MSB:`CFS_FLAG_LSB] = latchFlags_q; // [RULE1]
        end else if (isRead && hitFault) begin
            readData_d[`CFS_FLAG_MSB:`CFS_FLAG_LSB] = dsFlags_q; // [RULE7]
        end
    end

    // Data is held between reads so the shifter may sample it late.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            readData_q <= `CFS_RST_RDATA;
            readValid_q <= 1'b0;
        end else begin
            readValid_q <= readValid_d;
            if (isRead) begin
                readData_q <= readData_d;
            end
        end
    end

    // Outputs come straight from the registers.
    assign readData = readData_q;
    assign readValid = readValid_q;
    assign channelLatchedOff = latchFlags_q;
    assign globalLatchOff = anyLatch_q;

    // ==========================================================
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    cfs_chan_t latchEvt;
    cfs_chan_t timerOnly;
    cfs_chan_t evalCmp;

    // Helper terms sampled by the checks below.
    always_comb begin
        latchEvt = frozen ? 4'h0 : latchOffEvent;
        timerOnly = timerConfigWrite & ~latchOffEvent & ~pendLatch_q;
        evalCmp = evalNow & cmpSyncB_q;
    end

    sequence rcReq;
        faultReadClr && (evalNow == 4'h0);
    endsequence

    sequence rcDone;
        (dsFlags_q == 4'h0) && readValid_q;
    endsequence

    AST_RSVD_ZERO: assert property ( // [RULE1]
        readData_q[`CFS_RSVD_MSB:`CFS_RSVD_LSB] == 4'h0)
        else $error("reserved read bits not zero");

    AST_LATCH_SET: assert property ( // [RULE2]
        (latchEvt != 4'h0) && !softReset |=>
        (latchFlags_q & $past(latchEvt)) == $past(latchEvt))
        else $error("latch-off event did not set its flag");

    AST_TIMER_CLR: assert property ( // [RULE3]
        (timerOnly != 4'h0) && !frozen |=>
        (latchFlags_q & $past(timerOnly)) == 4'h0)
        else $error("timer write did not clear latch-off flag");

    AST_SOFT_RST: assert property ( // [RULE4]
        softReset |=> (latchFlags_q == 4'h0) && !globalLatchOff)
        else $error("software reset left a latch-off flag");

    AST_DS_EVAL: assert property ( // [RULE5]
        (evalNow != 4'h0) |=>
        (dsFlags_q & $past(evalNow)) == $past(evalCmp))
        else $error("drain-source flag not sampled at turn-off");

    AST_DS_HOLD: assert property ( // [RULE6]
        (evalNow == 4'h0) && !faultReadClr |=> $stable(dsFlags_q))
        else $error("drain-source flag moved without turn-off");

    AST_DS_RC: assert property ( // [RULE7]
        rcReq |=> rcDone ##0 (readData_q[3:0] == $past(dsFlags_q)))
        else $error("read-and-clear did not return and clear");

    AST_DS_ONE: assert property ( // [RULE8]
        (evalNow != 4'h0) && ((evalNow & cmpSyncB_q) == 4'h0) |=>
        (dsFlags_q & $past(evalNow)) == 4'h0)
        else $error("flag set with no high drop seen");

    AST_FROZEN: assert property ( // [RULE9]
        frozen && !faultReadClr |=> $stable(dsFlags_q))
        else $error("drain-source flags updated inside a frame");

    AST_FROZEN_LATCH: assert property ( // [RULE9]
        frozen && !softReset && (timerConfigWrite == 4'h0) |=>
        $stable(latchFlags_q))
        else $error("latch-off flags updated inside a frame");

    AST_GLOBAL: assert property ( // [RULE10]
        globalLatchOff == (latchFlags_q != 4'h0))
        else $error("global latch-off bit disagrees with flags");

endmodule // cfs_status_regs

`default_nettype wire

// ### test_cfs_status_regs.sv
// Self-checking bench for the channel fault status registers.
`include "cfs_regs_map.svh"
`timescale 1ns/100ps
`default_nettype none
`define TB_CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
    n_fail++; $display("[ERR] %0t got %h want %h", $time, g, e); end end

module test_cfs_status_regs
    import cfs_pkg::*;
;
    typedef struct {cfs_chan_t ov, lo, co; cfs_byte_t lat, ds;} cfs_row_t;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic chipSelectN, softReset, readValid, globalLatchOff, timedOut;
    cfs_acc_t regAccess;
    logic [7:0] regAddr;
    cfs_chan_t timerConfigWrite, channelLatchedOff;
    cfs_chan_t latchOffEvent = 4'h0;
    cfs_chan_t commandOffEvent = 4'h0;
    cfs_chan_t overloadCmp = 4'h0;
    cfs_byte_t readData, d;
    cfs_row_t rows[4];
    int n_fail = 0;
    int n_compared = 0;

    // Free running 50 MHz clock.
    always #10 clk = ~clk;

    cfs_status_regs cfs_status_regs_inst (.clk(clk), .reset(reset),
        .chipSelectN(chipSelectN), .regAccess(regAccess),
        .regAddr(regAddr), .timerConfigWrite(timerConfigWrite),
        .softReset(softReset), .latchOffEvent(latchOffEvent),
        .commandOffEvent(commandOffEvent), .overloadCmp(overloadCmp),
        .readData(readData), .readValid(readValid),
        .channelLatchedOff(channelLatchedOff),
        .globalLatchOff(globalLatchOff));

    cfs_host_model cfs_host_model_inst (.clk(clk), .readValid(readValid),
        .readData(readData), .chipSelectN(chipSelectN),
        .regAccess(regAccess), .regAddr(regAddr),
        .timerConfigWrite(timerConfigWrite), .softReset(softReset),
        .timedOut(timedOut));

    // ==========================================================
    // Verdict and closing report.
    task automatic end_sim();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // A missing answer ends the run at once.
    task automatic rd(input cfs_acc_t k, input logic [7:0] a);
        cfs_host_model_inst.access(k, a, d);
        if (timedOut) begin
            n_fail++;
            end_sim();
        end
    endtask

    // The comparator settles through its synchroniser before the pulse.
    task automatic ev(input cfs_chan_t ov, input cfs_chan_t lo,
                      input cfs_chan_t co);
        @(posedge clk);
        overloadCmp <= ov;
        repeat (3) @(posedge clk);
        latchOffEvent <= lo;
        commandOffEvent <= co;
        @(posedge clk);
        latchOffEvent <= 4'h0;
        commandOffEvent <= 4'h0;
        @(posedge clk);
        #1;
    endtask

    // ==========================================================
    // Table of turn-off cases, then the awkward cases by hand.
    initial begin
        rows = '{'{4'h1, 4'h1, 4'h0, 8'h01, 8'h01},
                 '{4'h8, 4'h0, 4'ha, 8'h00, 8'h08},
                 '{4'hf, 4'hc, 4'h3, 8'h0c, 8'h0f},
                 '{4'hf, 4'h0, 4'h0, 8'h00, 8'h00}};
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd(CFS_ACC_READ, `CFS_OFF_LATCHOFF);
        `TB_CHK(d, 8'h00)
        rd(CFS_ACC_READ, `CFS_OFF_DSFAULT);
        `TB_CHK(d, 8'h00)
        rd(CFS_ACC_READ, 8'h34);
        `TB_CHK(d, 8'h00)
        foreach (rows[i]) begin
            ev(rows[i].ov, rows[i].lo, rows[i].co);
            `TB_CHK(channelLatchedOff, rows[i].lat[3:0])
            `TB_CHK(globalLatchOff, |rows[i].lat)
            rd(CFS_ACC_READ, `CFS_OFF_LATCHOFF);
            `TB_CHK(d, rows[i].lat)
            rd(CFS_ACC_READCLR, `CFS_OFF_DSFAULT);
            `TB_CHK(d, rows[i].ds)
            rd(CFS_ACC_READ, `CFS_OFF_DSFAULT);
            `TB_CHK(d, 8'h00)
            cfs_host_model_inst.ctrl(4'hf, 1'b0);
            `TB_CHK(channelLatchedOff, 4'h0)
        end
        // Read-and-clear must not touch the read-only latch flags.
        ev(4'h1, 4'h5, 4'h0);
        rd(CFS_ACC_READCLR, `CFS_OFF_LATCHOFF);
        rd(CFS_ACC_READ, `CFS_OFF_LATCHOFF);
        `TB_CHK(d, 8'h05)
        cfs_host_model_inst.ctrl(4'h1, 1'b0);
        `TB_CHK(channelLatchedOff, 4'h4)
        `TB_CHK(globalLatchOff, 1'b1)
        cfs_host_model_inst.ctrl(4'h0, 1'b1);
        `TB_CHK(channelLatchedOff, 4'h0)
        `TB_CHK(globalLatchOff, 1'b0)
        rd(CFS_ACC_READ, `CFS_OFF_DSFAULT);
        `TB_CHK(d, 8'h01)
        ev(4'h0, 4'h0, 4'h1);
        rd(CFS_ACC_READ, `CFS_OFF_DSFAULT);
        `TB_CHK(d, 8'h00)
        // Events inside a frame: latch parked, drain-source dropped.
        cfs_host_model_inst.setCs(1'b0);
        repeat (3) @(posedge clk);
        ev(4'h2, 4'h8, 4'h2);
        `TB_CHK(channelLatchedOff, 4'h0)
        rd(CFS_ACC_READ, `CFS_OFF_DSFAULT);
        `TB_CHK(d, 8'h00)
        cfs_host_model_inst.setCs(1'b1);
        repeat (4) @(posedge clk);
        #1;
        `TB_CHK(channelLatchedOff, 4'h8)
        rd(CFS_ACC_READ, `CFS_OFF_LATCHOFF);
        `TB_CHK(d, 8'h08)
        // A second reset in mid-run clears the latched state.
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        #1;
        `TB_CHK(channelLatchedOff, 4'h0)
        `TB_CHK(globalLatchOff, 1'b0)
        `TB_CHK(readData, 8'h00)
        `TB_CHK(readValid, 1'b0)
        @(posedge clk);
        reset <= 1'b0;
        rd(CFS_ACC_READ, `CFS_OFF_LATCHOFF);
        `TB_CHK(d, 8'h00)
        end_sim();
    end
endmodule // test_cfs_status_regs
`default_nettype wire
